//--- verilog/sfdb_pkg.sv
// ==========================================================
// register map and field layout
package sfdb_pkg;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h01;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h02;
  localparam logic [7:0] ADDR_FLAGS = 8'h03;
  localparam logic [7:0] ADDR_DATA = 8'h04;

  // mode register
  localparam int MODE_MASTER_BIT = 5;
  // control register
  localparam int CTRL_BUF_EN_BIT = 7;
  localparam int CTRL_SEL_DIS_BIT = 2;
  // interrupt enable register
  localparam int EN_RXC_BIT = 7;
  localparam int EN_TXC_BIT = 6;
  localparam int EN_DRE_BIT = 5;
  localparam int EN_SEL_BIT = 4;
  localparam int EN_GEN_BIT = 0;
  // flag register, normal view
  localparam int FLG_GENERAL_BIT = 7;
  localparam int FLG_WCOL_BIT = 6;
  // flag register, buffered view
  localparam int FLG_RXC_BIT = 7;
  localparam int FLG_TXC_BIT = 6;
  localparam int FLG_DRE_BIT = 5;
  localparam int FLG_SEL_BIT = 4;
  localparam int FLG_OVR_BIT = 0;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] RX_DEPTH = 2'h2;
  localparam int SYNC_STAGES = 2;
  localparam int PIN_COUNT = 3;
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SS_N = 2;
endpackage

//--- verilog/sfdb_top.sv
`timescale 1ns/1ns
module sfdb_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic irq_ack,
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  output logic miso,
  output logic miso_oe_n,
  output logic master_role,
  output logic irq
);
  // ==========================================================
  // pin synchronisers
  logic [sfdb_pkg::PIN_COUNT-1:0] pin_raw;
  logic [sfdb_pkg::PIN_COUNT-1:0] pin_s;
  assign pin_raw = {ss_n, mosi, sck};
  // select resets to its idle high level, so no false frame follows reset
  for (genvar gi = 0; gi < sfdb_pkg::PIN_COUNT; gi = gi + 1) begin : g_sync
    logic [sfdb_pkg::SYNC_STAGES-1:0] stage_q;
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        stage_q <= {sfdb_pkg::SYNC_STAGES{gi == sfdb_pkg::PIN_SS_N}};
      end else begin
        stage_q <= {stage_q[0], pin_raw[gi]};
      end
    end
    assign pin_s[gi] = stage_q[1];
  end
  logic sck_s;
  logic mosi_s;
  logic ss_n_s;
  logic sck_prev_q;
  assign sck_s = pin_s[sfdb_pkg::PIN_SCK];
  assign mosi_s = pin_s[sfdb_pkg::PIN_MOSI];
  assign ss_n_s = pin_s[sfdb_pkg::PIN_SS_N];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end
  // ==========================================================
  // register decode
  logic wr_mode, wr_ctrl, wr_en, wr_flags, wr_data, rd_flags, rd_data;
  assign wr_mode = reg_wr && (reg_addr == sfdb_pkg::ADDR_MODE);
  assign wr_ctrl = reg_wr && (reg_addr == sfdb_pkg::ADDR_CTRL);
  assign wr_en = reg_wr && (reg_addr == sfdb_pkg::ADDR_IRQ_EN);
  assign wr_flags = reg_wr && (reg_addr == sfdb_pkg::ADDR_FLAGS);
  assign wr_data = reg_wr && (reg_addr == sfdb_pkg::ADDR_DATA);
  assign rd_flags = reg_rd && (reg_addr == sfdb_pkg::ADDR_FLAGS);
  assign rd_data = reg_rd && (reg_addr == sfdb_pkg::ADDR_DATA);
  logic master_q;
  logic buf_en_q;
  logic sel_dis_q;
  logic [7:0] irq_en_q;
  // ==========================================================
  // shift engine (mode 0, msb first, external sck)
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic shift_full_q;
  logic frame_active;
  logic sck_rise;
  logic sck_fall;
  logic byte_done;
  logic byte_start;
  logic load_norm;
  logic load_buf;
  logic load;
  logic [7:0] load_val;
  logic [7:0] tx_buf_q;
  logic tx_full_q;
  // master role still takes sck from the pin: the divider lives outside
  assign frame_active = master_q || !ss_n_s;
  assign sck_rise = frame_active && sck_s && !sck_prev_q;
  assign sck_fall = frame_active && !sck_s && sck_prev_q;
  assign byte_done = sck_rise && (bit_cnt_q == sfdb_pkg::BITS_PER_BYTE - 4'h1);
  assign byte_start = sck_rise && (bit_cnt_q == 4'h0);
  // a load on the same cycle as a first edge would corrupt bit 7, so a buffered load waits and a direct write is lost
  // write starts transmission
  assign load_norm = wr_data && !buf_en_q && (bit_cnt_q == 4'h0) && !sck_rise;
  assign load_buf = buf_en_q && tx_full_q && !shift_full_q && (bit_cnt_q == 4'h0)
                    && !sck_rise;
  assign load = load_norm || load_buf;
  assign load_val = load_norm ? reg_wdata : tx_buf_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= sfdb_pkg::REG_RESET;
      bit_cnt_q <= 4'h0;
    end else if (sck_rise) begin
      shift_q <= {shift_q[6:0], mosi_s};
      bit_cnt_q <= byte_done ? 4'h0 : bit_cnt_q + 4'h1;
    end else if (load) begin
      shift_q <= load_val;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_full_q <= 1'b0;
    end else if (load_buf) begin
      shift_full_q <= 1'b1;
    end else if (byte_done) begin
      shift_full_q <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      miso <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= !frame_active;
      if (load) begin
        miso <= load_val[7];
      end else if (sck_fall) begin
        miso <= shift_q[7];
      end
    end
  end
  // ==========================================================
  // transmit buffer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_buf_q <= sfdb_pkg::REG_RESET;
      tx_full_q <= 1'b0;
    end else if (wr_data && buf_en_q) begin
      tx_buf_q <= reg_wdata;
      tx_full_q <= 1'b1;
    end else if (load_buf) begin
      tx_full_q <= 1'b0;
    end
  end
  // ==========================================================
  // receive buffer: entry2 is the oldest byte, the one software reads
  logic [7:0] rx_first_q;
  logic [7:0] rx_second_q;
  logic [1:0] rx_count_q;
  logic pop;
  logic overrun;
  assign pop = rd_data && buf_en_q && (rx_count_q != 2'h0);
  assign overrun = byte_done && buf_en_q && (rx_count_q == sfdb_pkg::RX_DEPTH) && !pop;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_first_q <= sfdb_pkg::REG_RESET;
      rx_second_q <= sfdb_pkg::REG_RESET;
      rx_count_q <= 2'h0;
    end else if (!buf_en_q) begin
      rx_count_q <= 2'h0;
      if (byte_done) begin
        rx_second_q <= {shift_q[6:0], mosi_s};
      end
    end else if (pop && byte_done) begin
      if (rx_count_q == 2'h1) begin
        rx_second_q <= {shift_q[6:0], mosi_s};
      end else begin
        rx_second_q <= rx_first_q;
        rx_first_q <= {shift_q[6:0], mosi_s};
      end
    end else if (pop) begin
      rx_second_q <= rx_first_q;
      rx_count_q <= rx_count_q - 2'h1;
    end else if (byte_done) begin
      if (rx_count_q == 2'h0) begin
        rx_second_q <= {shift_q[6:0], mosi_s};
        rx_count_q <= 2'h1;
      end else if (rx_count_q == 2'h1) begin
        rx_first_q <= {shift_q[6:0], mosi_s};
        rx_count_q <= sfdb_pkg::RX_DEPTH;
      end
    end
  end
  // ==========================================================
  // configuration registers
  logic sel_trigger;
  // select low in master, unless disabled
  assign sel_trigger = master_q && !ss_n_s && !sel_dis_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      master_q <= 1'b0;
    end else if (sel_trigger) begin
      master_q <= 1'b0;
    end else if (wr_mode) begin
      master_q <= reg_wdata[sfdb_pkg::MODE_MASTER_BIT];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_en_q <= 1'b0;
      sel_dis_q <= 1'b0;
      irq_en_q <= sfdb_pkg::REG_RESET;
    end else begin
      if (wr_ctrl) begin
        buf_en_q <= reg_wdata[sfdb_pkg::CTRL_BUF_EN_BIT];
        sel_dis_q <= reg_wdata[sfdb_pkg::CTRL_SEL_DIS_BIT];
      end
      if (wr_en) begin
        irq_en_q <= reg_wdata;
      end
    end
  end
  // ==========================================================
  // normal-view flags
  logic gen_flag_q;
  logic wcol_flag_q;
  logic gen_armed_q;
  logic wcol_armed_q;
  logic data_access;
  logic gen_set;
  logic wcol_set;
  assign data_access = rd_data || wr_data;
  // byte complete; select low in master
  assign gen_set = !buf_en_q && (byte_done || sel_trigger);
  assign wcol_set = wr_data && !buf_en_q && (bit_cnt_q != 4'h0 || sck_rise);
  // set wins over any clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gen_flag_q <= 1'b0;
      gen_armed_q <= 1'b0;
    end else if (gen_set) begin
      gen_flag_q <= 1'b1;
      gen_armed_q <= 1'b0;
    end else if (irq_ack || (data_access && gen_armed_q)) begin
      gen_flag_q <= 1'b0;
      gen_armed_q <= 1'b0;
    end else if (rd_flags) begin
      gen_armed_q <= gen_flag_q;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wcol_flag_q <= 1'b0;
      wcol_armed_q <= 1'b0;
    end else if (wcol_set) begin
      wcol_flag_q <= 1'b1;
      wcol_armed_q <= 1'b0;
    end else if (data_access && wcol_armed_q) begin
      wcol_flag_q <= 1'b0;
      wcol_armed_q <= 1'b0;
    end else if (rd_flags) begin
      wcol_armed_q <= wcol_flag_q;
    end
  end
  // ==========================================================
  // buffered-view flags
  logic rxc_q;
  logic txc_q;
  logic sel_q;
  logic ovr_q;
  logic ovr_pend_q;
  logic dre;
  logic w1c_rxc;
  logic w1c_txc;
  logic w1c_sel;
  assign w1c_rxc = wr_flags && buf_en_q && reg_wdata[sfdb_pkg::FLG_RXC_BIT];
  assign w1c_txc = wr_flags && buf_en_q && reg_wdata[sfdb_pkg::FLG_TXC_BIT];
  assign w1c_sel = wr_flags && buf_en_q && reg_wdata[sfdb_pkg::FLG_SEL_BIT];
  // empty when no byte waits; write fills it
  assign dre = !tx_full_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxc_q <= 1'b0;
    end else if (buf_en_q && byte_done) begin
      rxc_q <= 1'b1;
    end else if (w1c_rxc || (pop && rx_count_q == 2'h1) || !buf_en_q) begin
      // write one clears; reading empties the buffer
      rxc_q <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txc_q <= 1'b0;
    end else if (buf_en_q && byte_done && !tx_full_q && !wr_data) begin
      txc_q <= 1'b1;
    end else if (w1c_txc) begin
      txc_q <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= 1'b0;
    end else if (buf_en_q && sel_trigger) begin
      sel_q <= 1'b1;
    end else if (w1c_sel) begin
      sel_q <= 1'b0;
    end
  end
  // writes to the overrun position are ignored; software writes zero there
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovr_q <= 1'b0;
      ovr_pend_q <= 1'b0;
    end else if (overrun && tx_full_q) begin
      ovr_q <= 1'b1;
    end else if (overrun) begin
      ovr_pend_q <= 1'b1;
    end else if (ovr_pend_q && byte_start) begin
      ovr_q <= 1'b1;
      ovr_pend_q <= 1'b0;
    end else if (pop) begin
      ovr_q <= 1'b0;
      ovr_pend_q <= 1'b0;
    end
  end
  // ==========================================================
  // read data
  logic [7:0] flags_view;
  always_comb begin
    flags_view = sfdb_pkg::REG_RESET;
    if (buf_en_q) begin
      flags_view[sfdb_pkg::FLG_RXC_BIT] = rxc_q;
      flags_view[sfdb_pkg::FLG_TXC_BIT] = txc_q;
      flags_view[sfdb_pkg::FLG_DRE_BIT] = dre;
      flags_view[sfdb_pkg::FLG_SEL_BIT] = sel_q;
      flags_view[sfdb_pkg::FLG_OVR_BIT] = ovr_q;
    end else begin
      flags_view[sfdb_pkg::FLG_GENERAL_BIT] = gen_flag_q;
      flags_view[sfdb_pkg::FLG_WCOL_BIT] = wcol_flag_q;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= sfdb_pkg::REG_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        sfdb_pkg::ADDR_MODE: reg_rdata <= 8'(master_q) << sfdb_pkg::MODE_MASTER_BIT;
        sfdb_pkg::ADDR_CTRL: reg_rdata <= (8'(buf_en_q) << sfdb_pkg::CTRL_BUF_EN_BIT)
                                          | (8'(sel_dis_q) << sfdb_pkg::CTRL_SEL_DIS_BIT);
        sfdb_pkg::ADDR_IRQ_EN: reg_rdata <= irq_en_q;
        sfdb_pkg::ADDR_FLAGS: reg_rdata <= flags_view;
        sfdb_pkg::ADDR_DATA: reg_rdata <= rx_second_q;
        default: reg_rdata <= sfdb_pkg::READ_UNMAPPED;
      endcase
    end
  end
  // ==========================================================
  // interrupt request and role output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
      master_role <= 1'b0;
    end else begin
      master_role <= master_q;
      if (buf_en_q) begin
        irq <= (irq_en_q[sfdb_pkg::EN_RXC_BIT] && rxc_q)
               || (irq_en_q[sfdb_pkg::EN_TXC_BIT] && txc_q)
               || (irq_en_q[sfdb_pkg::EN_DRE_BIT] && dre)
               || (irq_en_q[sfdb_pkg::EN_SEL_BIT] && sel_q);
      end else begin
        irq <= irq_en_q[sfdb_pkg::EN_GEN_BIT] && gen_flag_q;
      end
    end
  end
endmodule

//--- tb/sfdb_far_master.sv
`timescale 1ns/1ns
// ========================================
// far-side master, mode 0, msb first
module sfdb_far_master (
  output logic sck,
  output logic mosi,
  output logic ss_n,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    mosi = 1'b1;
    ss_n = 1'b1;
  end

  // the 1 ns offset keeps link edges clear of core clock edges
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #1 ss_n = 1'b0;
    #32;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #16 sck = 1'b1;
      rx[i] = miso;
      #16 sck = 1'b0;
    end
    #16 ss_n = 1'b1;
    // released line shows the inverse so a stale bit cannot pass
    mosi = ~mosi;
    #32;
  endtask

  task automatic pulse_select;
    #1 ss_n = 1'b0;
    #64 ss_n = 1'b1;
    #32;
  endtask
endmodule

//--- tb/sfdb_top_chk.sv
`timescale 1ns/1ns
// ========================================
// port-level checks of the flag logic
module sfdb_top_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ss_n,
  input wire logic master_role,
  input wire logic irq
);
  logic buf_q;
  logic dis_q;
  logic [7:0] ien_q;
  logic frd;
  logic fwr;

  assign frd = reg_rd && reg_addr == sfdb_pkg::ADDR_FLAGS;
  assign fwr = reg_wr && reg_addr == sfdb_pkg::ADDR_FLAGS;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // shadow of the settings that decide which flags apply
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_q <= 1'b0;
      dis_q <= 1'b0;
    end else if (reg_wr && reg_addr == sfdb_pkg::ADDR_CTRL) begin
      buf_q <= reg_wdata[sfdb_pkg::CTRL_BUF_EN_BIT];
      dis_q <= reg_wdata[sfdb_pkg::CTRL_SEL_DIS_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ien_q <= 8'h00;
    end else if (reg_wr && reg_addr == sfdb_pkg::ADDR_IRQ_EN) begin
      ien_q <= reg_wdata;
    end
  end

  property wone(b);
    buf_q && fwr && reg_wdata[b] ##2 frd |=> !reg_rdata[b];
  endproperty

  view_norm_a: assert property (frd && !buf_q |=> reg_rdata[5:0] == 6'h00)
    else $error("normal flag view shows extra bits");
  view_buf_a: assert property (frd && buf_q |=> reg_rdata[3:1] == 3'h0)
    else $error("buffered flag view shows unused bits");
  drop_master_a: assert property (
    master_role && !dis_q && $fell(ss_n) |-> ##[1:8] !master_role)
    else $error("select low did not drop master role");
  keep_master_a: assert property (
    master_role && dis_q && !ss_n && !reg_wr |=> master_role)
    else $error("disabled select line dropped master role");
  irq_gen_a: assert property (
    frd && !buf_q && ien_q[0] ##1 reg_rdata[7] |-> irq)
    else $error("general flag set but no interrupt");
  irq_rxc_a: assert property (
    frd && buf_q && ien_q[7] ##1 reg_rdata[7] |-> irq)
    else $error("receive flag set but no interrupt");
  rxc_clear_a: assert property (wone(7))
    else $error("receive flag not cleared by write one");
  txc_clear_a: assert property (wone(6))
    else $error("transmit flag not cleared by write one");
  sel_clear_a: assert property (wone(4))
    else $error("select flag not cleared by write one");

  cover property (irq);
  cover property ($fell(master_role));
  cover property (frd ##1 reg_rdata[0]);
endmodule

bind sfdb_top sfdb_top_chk u_chk (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ss_n(ss_n),
  .master_role(master_role), .irq(irq)
);

//--- tb/tb_top.sv
`timescale 1ns/1ns
// ========================================
// flag and data buffer bench
module tb_top;
  typedef struct {
    logic [7:0] a;
    logic [7:0] w;
    logic we;
    logic [7:0] e;
  } sfdb_row_t;
  logic clk, reset_n, reg_wr, reg_rd, irq_ack, sck, mosi, ss_n;
  logic miso, miso_oe_n, master_role, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, r2;
  logic [2:0] pins;
  int errors, comparisons;
  sfdb_row_t rows [8];

  assign pins = {miso_oe_n, master_role, irq};

  sfdb_top u_dut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
    .sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(miso), .miso_oe_n(miso_oe_n),
    .master_role(master_role), .irq(irq)
  );
  sfdb_far_master u_far (.sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(miso));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // ========================================
  // register port, strobes spaced so none is set twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, reg_rdata & m, e);
    @(posedge clk);
  endtask

  task automatic rf(input logic [7:0] m, input logic [7:0] e);
    rc("flags", sfdb_pkg::ADDR_FLAGS, m, e);
  endtask

  task automatic rd(input logic [7:0] e);
    rc("data", sfdb_pkg::ADDR_DATA, 8'hFF, e);
  endtask

  // pin index: 0 irq, 1 master role, 2 output enable
  task automatic pk(input string n, input int i, input logic e);
    #1;
    chk(n, {7'h00, pins[i]}, {7'h00, e});
    @(posedge clk);
  endtask

  task automatic xf(input logic [7:0] t, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] r;
    u_far.xfer(t, r);
    repeat (4) @(posedge clk);
    chk("miso", r & m, e);
  endtask

  task automatic sel;
    u_far.pulse_select();
    repeat (4) @(posedge clk);
  endtask

  task automatic results;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    results();
  end

  // ========================================
  // main sequence
  initial begin
    errors = 0;
    comparisons = 0;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    irq_ack = 1'b0;
    rows = '{
      '{sfdb_pkg::ADDR_MODE, 8'h00, 1'b0, 8'h00},
      '{sfdb_pkg::ADDR_CTRL, 8'h00, 1'b0, 8'h00},
      '{sfdb_pkg::ADDR_FLAGS, 8'h00, 1'b0, 8'h00},
      '{sfdb_pkg::ADDR_DATA, 8'h00, 1'b0, 8'h00},
      '{8'h05, 8'h5A, 1'b1, 8'h00},
      '{8'hFF, 8'h00, 1'b0, 8'h00},
      '{sfdb_pkg::ADDR_FLAGS, 8'hC0, 1'b1, 8'h00},
      '{sfdb_pkg::ADDR_IRQ_EN, 8'h01, 1'b1, 8'h01}
    };
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    pk("oe_n", 2, 1'b1);
    pk("master", 1, 1'b0);
    pk("irq", 0, 1'b0);
    foreach (rows[i]) begin
      if (rows[i].we) begin
        wr(rows[i].a, rows[i].w);
      end
      rc("row", rows[i].a, 8'hFF, rows[i].e);
    end
    wr(sfdb_pkg::ADDR_DATA, 8'hA5);
    xf(8'h3C, 8'hFF, 8'hA5);
    rf(8'hFF, 8'h80);
    pk("irq", 0, 1'b1);
    rd(8'h3C);
    rf(8'hFF, 8'h00);
    pk("irq", 0, 1'b0);
    wr(sfdb_pkg::ADDR_DATA, 8'h11);
    fork
      u_far.xfer(8'h5E, r2);
      begin
        repeat (40) @(posedge clk);
        wr(sfdb_pkg::ADDR_DATA, 8'h22);
      end
    join
    repeat (4) @(posedge clk);
    chk("miso", r2, 8'h11);
    rd(8'h5E);
    rf(8'hFF, 8'hC0);
    rd(8'h5E);
    rf(8'hFF, 8'h00);
    wr(sfdb_pkg::ADDR_MODE, 8'h20);
    sel;
    pk("master", 1, 1'b0);
    rf(8'hFF, 8'h80);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    @(posedge clk);
    rf(8'hFF, 8'h00);
    wr(sfdb_pkg::ADDR_CTRL, 8'h80);
    rf(8'hFF, 8'h20);
    wr(sfdb_pkg::ADDR_IRQ_EN, 8'h80);
    xf(8'h01, 8'h00, 8'h00);
    rf(8'h80, 8'h80);
    pk("irq", 0, 1'b1);
    xf(8'h02, 8'h00, 8'h00);
    xf(8'h03, 8'h00, 8'h00);
    rf(8'h81, 8'h80);
    xf(8'h04, 8'h00, 8'h00);
    rf(8'h01, 8'h01);
    rd(8'h01);
    rd(8'h02);
    rf(8'h81, 8'h00);
    pk("irq", 0, 1'b0);
    xf(8'h05, 8'h00, 8'h00);
    // transmit complete was set by the receive-only bytes; clear it with receive
    wr(sfdb_pkg::ADDR_FLAGS, 8'hC0);
    rf(8'h80, 8'h00);
    rd(8'h05);
    wr(sfdb_pkg::ADDR_DATA, 8'h77);
    wr(sfdb_pkg::ADDR_DATA, 8'h66);
    rf(8'h20, 8'h00);
    xf(8'h00, 8'hFF, 8'h77);
    rf(8'h60, 8'h20);
    xf(8'h00, 8'hFF, 8'h66);
    rf(8'h60, 8'h60);
    wr(sfdb_pkg::ADDR_FLAGS, 8'h40);
    rf(8'h40, 8'h00);
    wr(sfdb_pkg::ADDR_MODE, 8'h20);
    sel;
    pk("master", 1, 1'b0);
    rf(8'h10, 8'h10);
    wr(sfdb_pkg::ADDR_FLAGS, 8'h10);
    rf(8'h10, 8'h00);
    wr(sfdb_pkg::ADDR_CTRL, 8'h84);
    wr(sfdb_pkg::ADDR_MODE, 8'h20);
    sel;
    pk("master", 1, 1'b1);
    pk("oe_n", 2, 1'b0);
    rf(8'h10, 8'h00);
    results();
  end
endmodule
